// [src/fifo_fill_pkg.sv]
// Constants for the FIFO host access and fill status block.
// Assumes a 32-bit AXI4-Lite register bus and 16 FIFO pairs of 32 bytes.
// Offsets are word indices: the byte address on the bus is four times the index.
package fifo_fill_pkg;
  localparam int          NUM_FIFOS      = 16;                 // FIFO count
  localparam int          FIFO_DEPTH     = 32;                 // Bytes per FIFO direction
  localparam int          PTR_W          = 5;                  // Z-counter width
  localparam logic [9:0]  OFF_FILL_BL0   = 10'h024;            // First fill status
  localparam logic [9:0]  OFF_FILL_BL1   = 10'h025;            // Second fill status
  localparam logic [9:0]  OFF_FILL_BL2   = 10'h026;            // Third fill status
  localparam logic [9:0]  OFF_FILL_BL3   = 10'h027;            // Fourth fill status
  localparam logic [9:0]  OFF_DATA_INC   = 10'h080;            // Data port, advancing
  localparam logic [9:0]  OFF_DATA_HOLD  = 10'h084;            // Data port, holding
  localparam logic [9:0]  OFF_CH_MASK    = 10'h0f4;            // Channel bit mask
  localparam logic [9:0]  OFF_FIFO_SEL   = 10'h100;            // FIFO select
  localparam logic [9:0]  OFF_THRESHOLD  = 10'h104;            // Threshold config
  localparam logic [9:0]  OFF_SUBCH_CFG  = 10'h108;            // Sub-channel config
  localparam logic [9:0]  OFF_IRQ_STAT   = 10'h10c;            // Interrupt status
  localparam logic [9:0]  OFF_IRQ_MASK   = 10'h110;            // Interrupt mask
  localparam logic [9:0]  OFF_USAGE      = 10'h114;            // Byte count of selected
  localparam int          TX_THR_LSB     = 0;                  // Tx threshold field
  localparam int          RX_THR_LSB     = 4;                  // Rx threshold field
  localparam int          THR_SHIFT      = 1;                  // Threshold = field * 2
  localparam int          SEL_DIR_BIT    = 0;                  // Select bit 0: 1 = receive
  localparam int          SEL_NUM_LSB    = 1;                  // Select bits 4:1: FIFO number
  localparam int          TRP_BIT        = 3;                  // Subch cfg bit 3: transparent
  localparam logic [7:0]  CH_MASK_RST    = 8'hff;              // Mask reset value
  localparam logic [7:0]  THR_RST        = 8'h00;              // Threshold reset value
  localparam logic [1:0]  RESP_OKAY      = 2'b00;              // AXI okay
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;              // AXI slave error
endpackage

// [src/fifo_host_access_fill_status.sv]
// Host access port, channel mask and fill-level status for 16 tx/rx FIFO pairs.
// Assumes a single aclk domain; serializer requests come from same-clock logic.
// Behaviour
// - Fill flag high when count exceeds threshold
// - Tx and rx use separate threshold fields
// - Block 0 bits: even tx, odd rx
// - Blocks 1-3 hold FIFOs 4 to 15
// - All fill flags reset to zero
// - Advancing port moves byte, bumps Z-counter
// - Holding port moves byte, Z unchanged
// - Transparent tx repeats last held byte
// - Unprocessed bits take mask value, reset ones
// - Mask only when bit count non-zero
// - Fill level is stored byte count
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module fifo_host_access_fill_status (
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Synchronous reset, active low
  input  wire logic [11:0] s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [11:0] s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic        tx_pull,       // Serializer takes a byte from tx FIFO
  input  wire logic [3:0]  tx_pull_fifo,  // Which tx FIFO
  output logic [7:0]       tx_byte,       // Byte sent, mask applied
  output logic             tx_byte_valid, // Byte valid, one cycle
  input  wire logic        rx_push,       // Deserializer stores a byte
  input  wire logic [3:0]  rx_push_fifo,  // Which rx FIFO
  input  wire logic [7:0]  rx_push_data,  // Received byte
  output logic             irq            // Level interrupt
);
  localparam int N = fifo_fill_pkg::NUM_FIFOS;
  localparam int D = fifo_fill_pkg::FIFO_DEPTH;
  localparam int P = fifo_fill_pkg::PTR_W;

  // Storage: index {fifo, dir}, dir 1 = receive
  logic [7:0]   mem [0:2*N-1][0:D-1];      // FIFO bytes
  logic [P-1:0] wr_ptr [0:2*N-1];          // Z1 counters
  logic [P-1:0] rd_ptr [0:2*N-1];          // Z2 counters
  logic [P:0]   count  [0:2*N-1];          // Stored byte count
  logic [7:0]   ch_mask_reg [0:N-1];       // Per-channel mask
  logic [7:0]   subch_reg   [0:N-1];       // Per-channel bit count and mode
  logic [7:0]   sel_reg;                   // FIFO select
  logic [7:0]   thr_reg;                   // Threshold config
  logic [2*N-1:0] fill_reg;                // Fill flags, bit 2f tx, 2f+1 rx
  logic [2*N-1:0] irq_stat_reg;            // Sticky crossing events
  logic [2*N-1:0] irq_mask_reg;            // Interrupt enables

  logic [4:0] sel_idx;                     // Selected storage index
  logic [3:0] sel_ch;                      // Selected channel
  assign sel_ch  = sel_reg[fifo_fill_pkg::SEL_NUM_LSB +: 4];
  assign sel_idx = {sel_ch, sel_reg[fifo_fill_pkg::SEL_DIR_BIT]};

  // Write channel capture, either order
  logic        aw_held, w_held;            // Captured flags
  logic [11:0] aw_addr;                    // Captured address
  logic [31:0] w_data;                     // Captured data
  logic [3:0]  w_strb;                     // Captured strobes
  logic        wr_go;                      // Both captured, no response pending
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  // Capture address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h0000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Word decode of a captured write
  logic wr_lane0;                          // Low byte lane written
  logic wr_data_inc, wr_data_hold, wr_known;
  assign wr_lane0     = wr_go && w_strb[0];
  assign wr_data_inc  = wr_lane0 && aw_addr[11:2] == fifo_fill_pkg::OFF_DATA_INC;
  assign wr_data_hold = wr_lane0 && aw_addr[11:2] == fifo_fill_pkg::OFF_DATA_HOLD;
  always_comb begin
    case (aw_addr[11:2])
      fifo_fill_pkg::OFF_FILL_BL0, fifo_fill_pkg::OFF_FILL_BL1,
      fifo_fill_pkg::OFF_FILL_BL2, fifo_fill_pkg::OFF_FILL_BL3,
      fifo_fill_pkg::OFF_DATA_INC, fifo_fill_pkg::OFF_DATA_HOLD,
      fifo_fill_pkg::OFF_CH_MASK, fifo_fill_pkg::OFF_FIFO_SEL,
      fifo_fill_pkg::OFF_THRESHOLD, fifo_fill_pkg::OFF_SUBCH_CFG,
      fifo_fill_pkg::OFF_IRQ_STAT, fifo_fill_pkg::OFF_IRQ_MASK,
      fifo_fill_pkg::OFF_USAGE: wr_known = 1'b1;
      default:                  wr_known = 1'b0;
    endcase
  end

  // Write response; fill status writes are ignored but answered okay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fifo_fill_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? fifo_fill_pkg::RESP_OKAY : fifo_fill_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; array ones follow the current select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_reg      <= 8'h00;
      thr_reg      <= fifo_fill_pkg::THR_RST;
      irq_mask_reg <= '0;
      for (int c = 0; c < N; c++) begin
        ch_mask_reg[c] <= fifo_fill_pkg::CH_MASK_RST;
        subch_reg[c]   <= 8'h00;
      end
    end else if (wr_lane0) begin
      case (aw_addr[11:2])
        fifo_fill_pkg::OFF_FIFO_SEL:  sel_reg <= w_data[7:0];
        fifo_fill_pkg::OFF_THRESHOLD: thr_reg <= w_data[7:0];
        // Mask writes with a receive FIFO selected are dropped
        fifo_fill_pkg::OFF_CH_MASK:   if (!sel_reg[fifo_fill_pkg::SEL_DIR_BIT]) ch_mask_reg[sel_ch] <= w_data[7:0];
        fifo_fill_pkg::OFF_SUBCH_CFG: subch_reg[sel_ch] <= w_data[7:0];
        fifo_fill_pkg::OFF_IRQ_MASK:  irq_mask_reg <= w_data[2*N-1:0];
        default: ;
      endcase
    end
  end

  // Read channel
  logic rd_go;                             // Read address accepted
  logic rd_data_inc;                       // Advancing port read
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go       = s_axi_arvalid && !s_axi_rvalid;
  assign rd_data_inc = rd_go && s_axi_araddr[11:2] == fifo_fill_pkg::OFF_DATA_INC;

  // Serializer pull: transmit-side byte at read pointer
  logic [4:0] pull_idx;                    // Tx storage index
  logic       pull_ok;                     // Tx FIFO has data
  assign pull_idx = {tx_pull_fifo, 1'b0};
  assign pull_ok  = tx_pull && count[pull_idx] != '0;

  // FIFO storage and Z-counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2*N; i++) begin
        wr_ptr[i] <= '0;
        rd_ptr[i] <= '0;
        count[i]  <= '0;
      end
    end else begin
      for (int i = 0; i < 2*N; i++) begin
        logic inc_w, inc_r;
        inc_w = 1'b0;
        inc_r = 1'b0;
        // Host writes tx; device pushes rx
        if (i[0] == 1'b0 && wr_data_inc && sel_idx == i[4:0] && count[i] != D[P:0]) inc_w = 1'b1;
        if (i[0] == 1'b1 && rx_push && {rx_push_fifo, 1'b1} == i[4:0] && count[i] != D[P:0]) inc_w = 1'b1;
        // Host reads rx; serializer pulls tx
        if (i[0] == 1'b1 && rd_data_inc && sel_idx == i[4:0] && count[i] != '0) inc_r = 1'b1;
        if (i[0] == 1'b0 && pull_ok && pull_idx == i[4:0]) inc_r = 1'b1;
        if (inc_w) wr_ptr[i] <= wr_ptr[i] + 1'b1;
        if (inc_r) rd_ptr[i] <= rd_ptr[i] + 1'b1;
        if (inc_w && !inc_r) count[i] <= count[i] + 1'b1;
        else if (inc_r && !inc_w) count[i] <= count[i] - 1'b1;
      end
    end
  end

  // Byte memory: host data port writes at Z1 of the selected tx FIFO
  always_ff @(posedge aclk) begin
    // A full FIFO keeps its oldest byte on an advancing write or a push
    if (((wr_data_inc && count[sel_idx] != D[P:0]) || wr_data_hold) && !sel_idx[0]) begin
      mem[sel_idx][wr_ptr[sel_idx]] <= w_data[7:0];
    end
    if (rx_push && count[{rx_push_fifo, 1'b1}] != D[P:0]) begin
      mem[{rx_push_fifo, 1'b1}][wr_ptr[{rx_push_fifo, 1'b1}]] <= rx_push_data;
    end
  end

  // Last held byte per tx FIFO, for transparent repeat
  logic [7:0] hold_byte [0:N-1];           // Last byte written via holding port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < N; c++) hold_byte[c] <= 8'hff;
    end else if (wr_data_hold && !sel_idx[0]) begin
      hold_byte[sel_ch] <= w_data[7:0];
    end
  end

  // Transmit byte with mask on unprocessed bits
  logic [7:0] raw_tx;                      // Byte before masking
  logic [7:0] subch;                       // Config of pulled channel
  logic [2:0] bcnt;                        // Processed bit count, 0 = full byte
  logic [7:0] keep;                        // Processed bit positions
  assign subch = subch_reg[tx_pull_fifo];
  assign bcnt  = subch[2:0];
  assign keep  = 8'hff >> (4'd8 - {1'b0, bcnt});
  always_comb begin
    if (pull_ok) raw_tx = mem[pull_idx][rd_ptr[pull_idx]];
    else if (subch[fifo_fill_pkg::TRP_BIT]) raw_tx = hold_byte[tx_pull_fifo];
    else raw_tx = 8'hff;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_byte       <= 8'hff;
      tx_byte_valid <= 1'b0;
    end else begin
      tx_byte_valid <= tx_pull;
      if (tx_pull) begin
        if (bcnt != 3'h0) tx_byte <= (raw_tx & keep) | (ch_mask_reg[tx_pull_fifo] & ~keep);
        else tx_byte <= raw_tx;
      end
    end
  end

  // Fill flags against per-direction thresholds
  logic [P:0] tx_thr, rx_thr;              // Thresholds in bytes
  assign tx_thr = {2'b00, thr_reg[fifo_fill_pkg::TX_THR_LSB +: 4]} << fifo_fill_pkg::THR_SHIFT;
  assign rx_thr = {2'b00, thr_reg[fifo_fill_pkg::RX_THR_LSB +: 4]} << fifo_fill_pkg::THR_SHIFT;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_reg <= '0;
    end else begin
      for (int i = 0; i < 2*N; i++) begin
        fill_reg[i] <= count[i] > (i[0] ? rx_thr : tx_thr);
      end
    end
  end

  // Sticky crossing events; a new rise wins over a clear
  logic [2*N-1:0] fill_prev;               // Flags one cycle back
  logic [2*N-1:0] irq_clr;                 // Write-one-to-clear bits
  assign irq_clr = (wr_lane0 && aw_addr[11:2] == fifo_fill_pkg::OFF_IRQ_STAT) ? w_data[2*N-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_prev    <= '0;
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      fill_prev    <= fill_reg;
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | (fill_reg & ~fill_prev);
      irq          <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data mux; fill blocks pack four FIFOs each
  logic [31:0] rd_val;                     // Selected read word
  logic        rd_known;                   // Address mapped
  always_comb begin
    rd_val   = 32'h0000_0000;
    rd_known = 1'b1;
    case (s_axi_araddr[11:2])
      fifo_fill_pkg::OFF_FILL_BL0:  rd_val[7:0] = fill_reg[7:0];
      fifo_fill_pkg::OFF_FILL_BL1:  rd_val[7:0] = fill_reg[15:8];
      fifo_fill_pkg::OFF_FILL_BL2:  rd_val[7:0] = fill_reg[23:16];
      fifo_fill_pkg::OFF_FILL_BL3:  rd_val[7:0] = fill_reg[31:24];
      fifo_fill_pkg::OFF_DATA_INC,
      fifo_fill_pkg::OFF_DATA_HOLD: rd_val[7:0] = mem[sel_idx][rd_ptr[sel_idx]];
      fifo_fill_pkg::OFF_CH_MASK:   rd_val[7:0] = ch_mask_reg[sel_ch];
      fifo_fill_pkg::OFF_FIFO_SEL:  rd_val[7:0] = sel_reg;
      fifo_fill_pkg::OFF_THRESHOLD: rd_val[7:0] = thr_reg;
      fifo_fill_pkg::OFF_SUBCH_CFG: rd_val[7:0] = subch_reg[sel_ch];
      fifo_fill_pkg::OFF_IRQ_STAT:  rd_val[2*N-1:0] = irq_stat_reg;
      fifo_fill_pkg::OFF_IRQ_MASK:  rd_val[2*N-1:0] = irq_mask_reg;
      fifo_fill_pkg::OFF_USAGE:     rd_val[P:0] = count[sel_idx];
      default:                      rd_known = 1'b0;
    endcase
  end

  // Read response, one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= fifo_fill_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_known ? fifo_fill_pkg::RESP_OKAY : fifo_fill_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // fifo_host_access_fill_status
`default_nettype wire

// [tb/fifo_fill_chk.sv]
// Port-level checker for the FIFO host access and fill status block.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fifo_fill_chk (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset, active low
  input wire logic        s_axi_awready, // Write address ready
  input wire logic        s_axi_wready,  // Write data ready
  input wire logic [1:0]  s_axi_bresp,   // Write response
  input wire logic        s_axi_bvalid,  // Write response valid
  input wire logic        s_axi_bready,  // Write response ready
  input wire logic [11:0] s_axi_araddr,  // Read address
  input wire logic        s_axi_arvalid, // Read address valid
  input wire logic        s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic [1:0]  s_axi_rresp,   // Read response
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic        s_axi_rready,  // Read data ready
  input wire logic        tx_pull,       // Serializer request
  input wire logic [7:0]  tx_byte,       // Sent byte
  input wire logic        tx_byte_valid, // Sent byte valid
  input wire logic        irq            // Interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers and their hold
  chk_write_answer: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write answer without both channels held");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_fill_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr inside {[12'h090:12'h09f]}
    |=> s_axi_rresp == 2'b00 && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("fill status read malformed");
  chk_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h800
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  // Transmit byte timing and idle outputs after reset
  chk_tx_answer: assert property (tx_pull |=> tx_byte_valid)
    else $error("no byte after pull");
  chk_tx_cause: assert property (tx_byte_valid |-> $past(tx_pull))
    else $error("byte without pull");
  chk_reset_idle: assert property ($rose(aresetn) |-> !irq && !tx_byte_valid && tx_byte == 8'hff)
    else $error("outputs not idle after reset");
  cover property (tx_byte_valid);
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // fifo_fill_chk
bind fifo_host_access_fill_status fifo_fill_chk fifo_fill_chk_inst (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_pull, .tx_byte, .tx_byte_valid, .irq);
`default_nettype wire

// [tb/fifo_host_access_fill_status_tb_top.sv]
// Self-checking bench: register sequences through the host model.
// Assumes fill threshold field times two and FIFO depth 32.
`timescale 1ns/1ps
`default_nettype none
module fifo_host_access_fill_status_tb_top;
  logic        aclk = 1'b0;                                    // Clock
  logic        aresetn = 1'b0;                                 // Reset
  logic [11:0] s_axi_awaddr, s_axi_araddr;                     // Addresses
  logic [31:0] s_axi_wdata, s_axi_rdata;                       // Data
  logic [3:0]  s_axi_wstrb;                                    // Strobes
  logic [1:0]  s_axi_bresp, s_axi_rresp;                       // Responses
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, tx_byte_valid, irq;
  logic        tx_pull = 1'b0, rx_push = 1'b0;                 // Link strobes
  logic [3:0]  tx_pull_fifo = 4'h0, rx_push_fifo = 4'h0;       // Link FIFO numbers
  logic [7:0]  rx_push_data = 8'h00, tx_byte;                  // Link bytes
  int          err_count = 0, num_checks = 0;                  // Tallies
  always #5 aclk = ~aclk;
  fifo_host_access_fill_status fifo_host_access_fill_status_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_pull, .tx_pull_fifo, .tx_byte, .tx_byte_valid, .rx_push, .rx_push_fifo,
    .rx_push_data, .irq);
  host_bus_master host_bus_master_inst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Compare and tally
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register tasks take a word index; the byte address is four times it
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic [1:0] r;
    host_bus_master_inst.write({a, 2'b00}, d, r);
    check({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er = 2'b00);
    logic [31:0] d;
    logic [1:0]  r;
    host_bus_master_inst.read({a, 2'b00}, d, r);
    check(d, ed);
    check({30'h0, r}, {30'h0, er});
  endtask
  // Receive byte from the link side
  task automatic push(input logic [3:0] f, input logic [7:0] d);
    @(posedge aclk);
    rx_push <= 1'b1;
    rx_push_fifo <= f;
    rx_push_data <= d;
    @(posedge aclk);
    rx_push <= 1'b0;
  endtask
  // Transmit byte taken by the serializer, seen one cycle later
  task automatic pull(input logic [7:0] exp);
    @(posedge aclk);
    tx_pull <= 1'b1;
    @(posedge aclk);
    tx_pull <= 1'b0;
    @(negedge aclk);
    check({24'h0, tx_byte}, {24'h0, exp});
    check({31'h0, tx_byte_valid}, 32'h0000_0001);
  endtask
  task automatic irq_is(input logic e);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    check({31'h0, irq}, {31'h0, e});
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #200_000;
    err_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(10'h024 + 10'(i), 32'h0000_0000);
    wr(10'h100, 32'h0000_0000);
    rd(10'h0f4, 32'h0000_00ff);
    $display("test reset done");
    wr(10'h104, 32'h0000_0021);
    wr(10'h100, 32'h0000_000a);
    for (int i = 0; i < 3; i++) wr(10'h080, 32'h0000_00a0 + i);
    rd(10'h025, 32'h0000_0004);
    wr(10'h084, 32'h0000_0077);
    rd(10'h114, 32'h0000_0003);
    wr(10'h025, 32'h0000_0000);
    rd(10'h025, 32'h0000_0004);
    for (int i = 0; i < 4; i++) push(4'h9, 8'h10 + 8'(i));
    rd(10'h026, 32'h0000_0000);
    push(4'h9, 8'h14);
    rd(10'h026, 32'h0000_0008);
    wr(10'h100, 32'h0000_0013);
    rd(10'h084, 32'h0000_0010);
    rd(10'h114, 32'h0000_0005);
    rd(10'h080, 32'h0000_0010);
    rd(10'h114, 32'h0000_0004);
    rd(10'h026, 32'h0000_0000);
    $display("test fill done");
    wr(10'h100, 32'h0000_0000);
    wr(10'h108, 32'h0000_0003);
    wr(10'h0f4, 32'h0000_00a5);
    wr(10'h100, 32'h0000_0001);
    wr(10'h0f4, 32'h0000_0000);
    wr(10'h100, 32'h0000_0000);
    wr(10'h080, 32'h0000_005f);
    wr(10'h080, 32'h0000_0000);
    rd(10'h024, 32'h0000_0000);
    wr(10'h080, 32'h0000_00ff);
    rd(10'h024, 32'h0000_0001);
    pull(8'h07 | 8'ha0);
    pull(8'h00 | 8'ha0);
    pull(8'h07 | 8'ha0);
    wr(10'h108, 32'h0000_0008);
    wr(10'h084, 32'h0000_003c);
    pull(8'h3c);
    pull(8'h3c);
    $display("test transmit done");
    irq_is(1'b0);
    wr(10'h110, 32'hffff_ffff);
    irq_is(1'b1);
    wr(10'h10c, 32'hffff_ffff);
    irq_is(1'b0);
    rd(10'h10c, 32'h0000_0000);
    push(4'h9, 8'h15);
    irq_is(1'b1);
    $display("test interrupt done");
    rd(10'h200, 32'h0000_0000, 2'b10);
    wr(10'h200, 32'h0000_0000, 2'b10);
    $display("test unmapped done");
    finish_test();
  end
endmodule // fifo_host_access_fill_status_tb_top
`default_nettype wire

// [tb/host_bus_master.sv]
// Host processor model: AXI4-Lite master with one write and one read task.
// Assumes a single clock; answers are awaited without a cycle limit.
`timescale 1ns/1ps
`default_nettype none
module host_bus_master (
  input  wire logic        aclk,          // Clock
  output logic [11:0]      s_axi_awaddr,  // Write address
  output logic             s_axi_awvalid, // Write address valid
  input  wire logic        s_axi_awready, // Write address ready
  output logic [31:0]      s_axi_wdata,   // Write data
  output logic [3:0]       s_axi_wstrb,   // Write strobes
  output logic             s_axi_wvalid,  // Write data valid
  input  wire logic        s_axi_wready,  // Write data ready
  input  wire logic [1:0]  s_axi_bresp,   // Write response
  input  wire logic        s_axi_bvalid,  // Write response valid
  output logic             s_axi_bready,  // Write response ready
  output logic [11:0]      s_axi_araddr,  // Read address
  output logic             s_axi_arvalid, // Read address valid
  input  wire logic        s_axi_arready, // Read address ready
  input  wire logic [31:0] s_axi_rdata,   // Read data
  input  wire logic [1:0]  s_axi_rresp,   // Read response
  input  wire logic        s_axi_rvalid,  // Read data valid
  output logic             s_axi_rready   // Read data ready
);
  // Idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // Address and data offered together, each released when taken
  task automatic write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Read address released when taken; ready held until the answer is sampled
  task automatic read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // host_bus_master
`default_nettype wire
